// ### src/eeprom_i2c_defs.svh
// constants for the serial eeprom target write path
`ifndef EEPROM_I2C_DEFS_SVH
`define EEPROM_I2C_DEFS_SVH

`define TYPE_ARRAY      4'hA
`define TYPE_IDPAGE     4'hB
`define BIT_LAST        4'h7
`define BIT_ACK         4'h8
`define LAST_GROUP      3'h7
`define ECC_W           6
`define CODE_LAST_POS   32'h0000_0026
`define CLK_PERIOD_NS   32'h0000_0019
`define NS_PER_US       32'h0000_03E8
`define WRITE_TIME_US   32'h0000_03E8
`define TIMER_W         24

`endif

// ### src/eeprom_i2c_pkg.sv
// types and ecc helpers for the serial eeprom target
`include "eeprom_i2c_defs.svh"
package eeprom_i2c_pkg;

    typedef enum logic [2:0] {LS_SELECT, LS_ADDR_HI, LS_ADDR_LO, LS_DATA, LS_IGNORE} link_state_t;
    typedef enum logic [1:0] {CS_IDLE, CS_MERGE, CS_WAIT} commit_state_t;

    typedef struct packed {
        logic [3:0] dev_type;
        logic [2:0] chip;
        logic       read;
    } sel_byte_t;

    typedef struct packed {
        logic [`ECC_W-1:0] chk;
        logic [31:0]       data;
    } ecc_group_t;

    // hamming position of data bit i, skipping powers of two
    function automatic int code_pos(input int i);
        int n;
        n = 0;
        code_pos = 0;
        for (int p = 3; p <= `CODE_LAST_POS; p++)
        begin
            if ((p & (p - 1)) != 0)
            begin
                if (n == i)
                    code_pos = p;
                n++;
            end
        end
    endfunction

    function automatic logic [`ECC_W-1:0] ecc_gen(input logic [31:0] d);
        logic [`ECC_W-1:0] p;
        p = '0;
        for (int i = 0; i < 32; i++)
            for (int k = 0; k < `ECC_W; k++)
                if (((code_pos(i) >> k) & 1) != 0)
                    p[k] = p[k] ^ d[i];
        return p;
    endfunction

    // single-bit correction; a flipped check bit leaves data untouched
    function automatic logic [31:0] ecc_fix(input ecc_group_t g);
        logic [`ECC_W-1:0] syn;
        logic [31:0]       d;
        syn = ecc_gen(g.data) ^ g.chk;
        d = g.data;
        for (int i = 0; i < 32; i++)
            if (int'(syn) == code_pos(i))
                d[i] = ~d[i];
        return d;
    endfunction

endpackage

// ### src/eeprom_i2c_target.sv
`timescale 1ns/100ps
`include "eeprom_i2c_defs.svh"
module eeprom_i2c_target
    import eeprom_i2c_pkg::*;
#(
    parameter int WRITE_CYCLES = (`WRITE_TIME_US * `NS_PER_US + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
)
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_srst,
    input  wire logic        i_scl,
    input  wire logic        i_sda_i,
    output logic             o_sda_o,
    output logic             o_sda_oe,
    input  wire logic        i_chip_sel_bit2,
    input  wire logic        i_chip_sel_bit1,
    input  wire logic        i_chip_sel_bit0,
    input  wire logic        i_write_protect_in,
    input  wire logic [12:0] i_peek_addr,
    output logic [7:0]       o_peek_data,
    output logic             o_busy
);

    // link domain: everything below up to the bus watch runs on the bus clock, except the start toggle, which is clocked by the data line
    logic [1:0]  srst_l_reg;
    logic [1:0]  busy_l_reg;
    logic [1:0]  wp_l_reg;
    logic [2:0]  chip_l1_reg;
    logic [2:0]  chip_l2_reg;
    logic        srst_l;

    always_ff @(posedge i_scl)
    begin
        srst_l_reg  <= {srst_l_reg[0], i_srst};
        busy_l_reg  <= {busy_l_reg[0], o_busy};
        wp_l_reg    <= {wp_l_reg[0], i_write_protect_in};
        chip_l1_reg <= {i_chip_sel_bit2, i_chip_sel_bit1, i_chip_sel_bit0};
        chip_l2_reg <= chip_l1_reg;
    end

    assign srst_l = srst_l_reg[1];

    // start toggles on the data line's own edge; the toggle is stable for the
    // whole hold and low phase before the first rising clock reads it
    logic start_tgl_reg = '0;
    logic start_tgl_next;

    always_comb
    begin
        start_tgl_next = i_scl ? ~start_tgl_reg : start_tgl_reg;
    end

    always_ff @(negedge i_sda_i)
    begin
        start_tgl_reg <= start_tgl_next;
    end

    link_state_t state_reg, state_next;
    logic [3:0]  bitcnt_reg, bitcnt_next;
    logic [6:0]  shift_reg, shift_next;
    logic        ack_reg, ack_next;
    logic        armed_reg, armed_next;
    logic        seen_reg = '0;
    logic        seen_next;
    logic        is_id_reg, is_id_next;
    logic [4:0]  addr_hi_reg, addr_hi_next;
    logic [12:0] addr_reg, addr_next;
    logic [31:0] mask_reg, mask_next;
    logic        buf_we;
    logic [7:0]  page_buf [32];
    logic [7:0]  byte_in;
    sel_byte_t   sel;
    logic        sel_hit;
    logic        start_pend;

    assign byte_in    = {shift_reg, i_sda_i};
    assign sel        = sel_byte_t'(byte_in);
    assign start_pend = start_tgl_reg != seen_reg;

    always_comb
    begin
        sel_hit = (sel.dev_type == `TYPE_ARRAY || sel.dev_type == `TYPE_IDPAGE)
                  && sel.chip == chip_l2_reg
                  && !busy_l_reg[1];
    end

    always_comb
    begin
        state_next   = state_reg;
        bitcnt_next  = bitcnt_reg;
        shift_next   = shift_reg;
        ack_next     = ack_reg;
        armed_next   = '0;
        seen_next    = seen_reg;
        is_id_next   = is_id_reg;
        addr_hi_next = addr_hi_reg;
        addr_next    = addr_reg;
        mask_next    = mask_reg;
        buf_we       = '0;
        if (start_pend)
        begin
            // this rising edge already carries the select byte's msb
            seen_next   = start_tgl_reg;
            state_next  = LS_SELECT;
            bitcnt_next = 4'h1;
            shift_next  = {6'h00, i_sda_i};
            ack_next    = '0;
        end
        else if (bitcnt_reg == `BIT_ACK)
        begin
            bitcnt_next = 4'h0;
        end
        else
        begin
            shift_next  = byte_in[6:0];
            bitcnt_next = bitcnt_reg + 4'h1;
            // only one bit of the next byte seen: a stop now lands in the tenth slot
            armed_next  = bitcnt_reg == 4'h0 && ack_reg && state_reg == LS_DATA
                          && mask_reg != 32'h0000_0000;
            if (bitcnt_reg == `BIT_LAST)
            begin
                ack_next = '0;
                unique case (state_reg)
                    LS_SELECT:
                    begin
                        if (!sel_hit)
                            state_next = LS_IGNORE;
                        else
                        begin
                            ack_next   = '1;
                            is_id_next = sel.dev_type == `TYPE_IDPAGE;
                            // reads are served elsewhere; this path only takes writes
                            state_next = sel.read ? LS_IGNORE : LS_ADDR_HI;
                        end
                    end
                    LS_ADDR_HI:
                    begin
                        ack_next     = '1;
                        addr_hi_next = byte_in[4:0];
                        state_next   = LS_ADDR_LO;
                    end
                    LS_ADDR_LO:
                    begin
                        ack_next   = '1;
                        addr_next  = is_id_reg ? {8'h00, byte_in[4:0]} : {addr_hi_reg, byte_in};
                        mask_next  = 32'h0000_0000;
                        state_next = LS_DATA;
                    end
                    LS_DATA:
                    begin
                        ack_next = !wp_l_reg[1] && !is_id_reg;
                        if (ack_next)
                        begin
                            buf_we = '1;
                            mask_next[addr_reg[4:0]] = '1;
                        end
                        addr_next[4:0] = addr_reg[4:0] + 5'h01;
                    end
                    LS_IGNORE:
                    begin
                        ack_next = '0;
                    end
                endcase
            end
        end
    end

    // counter is left past the last written byte after the write cycle
    always_ff @(posedge i_scl)
    begin
        if (srst_l)
        begin
            state_reg   <= LS_IGNORE;
            bitcnt_reg  <= 4'h0;
            shift_reg   <= 7'h00;
            ack_reg     <= '0;
            armed_reg   <= '0;
            is_id_reg   <= '0;
            addr_hi_reg <= 5'h00;
            addr_reg    <= 13'h0000;
            mask_reg    <= 32'h0000_0000;
            seen_reg    <= start_tgl_reg;
        end
        else
        begin
            state_reg   <= state_next;
            bitcnt_reg  <= bitcnt_next;
            shift_reg   <= shift_next;
            ack_reg     <= ack_next;
            armed_reg   <= armed_next;
            is_id_reg   <= is_id_next;
            addr_hi_reg <= addr_hi_next;
            addr_reg    <= addr_next;
            mask_reg    <= mask_next;
            seen_reg    <= seen_next;
        end
    end

    always_ff @(posedge i_scl)
    begin
        if (buf_we)
            page_buf[addr_reg[4:0]] <= byte_in;
    end

    // ack drive moves on falling clock so the ninth bit is steady at its rise
    logic sda_oe_reg = '0;
    logic sda_oe_next;

    always_comb
    begin
        sda_oe_next = bitcnt_reg == `BIT_ACK && ack_reg && !start_pend && !srst_l;
    end

    always_ff @(negedge i_scl)
    begin
        sda_oe_reg <= sda_oe_next;
    end

    assign o_sda_oe = sda_oe_reg;

    start_frame_a: assert property (@(posedge i_scl) disable iff (srst_l)
        start_pend |=> state_reg == LS_SELECT && bitcnt_reg == 4'h1)
        else $error("start did not open a select byte");

    sel_miss_a: assert property (@(posedge i_scl) disable iff (srst_l)
        (state_reg == LS_SELECT && bitcnt_reg == `BIT_LAST && !start_pend && !sel_hit)
        |=> state_reg == LS_IGNORE && !ack_reg)
        else $error("mismatched select was not dropped");

    busy_mute_a: assert property (@(posedge i_scl) disable iff (srst_l)
        (busy_l_reg[1] && state_reg == LS_SELECT && bitcnt_reg == `BIT_LAST && !start_pend)
        |=> !ack_reg ##1 !sda_oe_reg)
        else $error("select answered while busy");

    wp_nack_a: assert property (@(posedge i_scl) disable iff (srst_l)
        (state_reg == LS_DATA && bitcnt_reg == `BIT_LAST && !start_pend && wp_l_reg[1])
        |=> !ack_reg && mask_reg == $past(mask_reg))
        else $error("data byte taken under write protect");

    id_lock_a: assert property (@(posedge i_scl) disable iff (srst_l)
        (state_reg == LS_DATA && bitcnt_reg == `BIT_LAST && !start_pend && is_id_reg)
        |=> !ack_reg && mask_reg == $past(mask_reg))
        else $error("identification page data accepted");

    page_wrap_a: assert property (@(posedge i_scl) disable iff (srst_l)
        (state_reg == LS_DATA && bitcnt_reg == `BIT_LAST && !start_pend)
        |=> addr_reg[12:5] == $past(addr_reg[12:5]))
        else $error("page bits moved during page write");

    page_step_a: assert property (@(posedge i_scl) disable iff (srst_l)
        (state_reg == LS_DATA && bitcnt_reg == `BIT_LAST && !start_pend)
        |=> addr_reg[4:0] == $past(addr_reg[4:0]) + 5'h01)
        else $error("in-page counter did not advance");

    ack_window_a: assert property (@(negedge i_scl) disable iff (srst_l)
        (bitcnt_reg == `BIT_ACK && ack_reg && !start_pend) |=> sda_oe_reg ##1 !sda_oe_reg)
        else $error("ack not driven in ninth clock");

    // system domain: bus watch, commit engine and ecc array
    logic [1:0] scl_s_reg, sda_s_reg, armed_s_reg;
    logic       sda_d_reg, scl_d_reg;
    logic       stop_seen;

    always_ff @(posedge i_clk_sys)
    begin
        scl_s_reg   <= {scl_s_reg[0], i_scl};
        sda_s_reg   <= {sda_s_reg[0], i_sda_i};
        armed_s_reg <= {armed_s_reg[0], armed_reg};
        scl_d_reg   <= scl_s_reg[1];
        sda_d_reg   <= sda_s_reg[1];
    end

    assign stop_seen = scl_s_reg[1] && scl_d_reg && sda_s_reg[1] && !sda_d_reg;

    commit_state_t       cstate_reg, cstate_next;
    logic [2:0]          grp_reg, grp_next;
    logic [`TIMER_W-1:0] timer_reg, timer_next;
    logic                busy_reg, busy_next;
    logic [7:0]          page_reg, page_next;
    logic                used_reg, used_next;
    logic                mem_we;
    ecc_group_t          mem_wdata;
    logic [31:0]         old_data;
    logic [3:0]          gmask;
    logic [7:0]          peek_next;
    logic [31:0]         peek_word;
    logic                sda_o_reg;
    ecc_group_t          mem [2048];

    // page_buf and mask are read here only while the link is parked behind busy, and the
    // address at the stop that raises busy, so they cannot move under the commit
    always_comb
    begin
        cstate_next = cstate_reg;
        grp_next    = grp_reg;
        timer_next  = timer_reg;
        busy_next   = busy_reg;
        page_next   = page_reg;
        used_next   = used_reg && armed_s_reg[1];
        mem_we      = '0;
        old_data    = ecc_fix(mem[{page_reg, grp_reg}]);
        gmask       = mask_reg[{grp_reg, 2'h0} +: 4];
        mem_wdata   = '0;
        for (int k = 0; k < 4; k++)
            mem_wdata.data[8 * k +: 8] = gmask[k] ? page_buf[{grp_reg, 2'(k)}]
                                                  : old_data[8 * k +: 8];
        mem_wdata.chk = ecc_gen(mem_wdata.data);
        unique case (cstate_reg)
            CS_IDLE:
            begin
                if (stop_seen && armed_s_reg[1] && !used_reg)
                begin
                    busy_next   = '1;
                    used_next   = '1;
                    grp_next    = 3'h0;
                    page_next   = addr_reg[12:5];
                    cstate_next = CS_MERGE;
                end
            end
            CS_MERGE:
            begin
                mem_we   = gmask != 4'h0;
                grp_next = grp_reg + 3'h1;
                if (grp_reg == `LAST_GROUP)
                begin
                    timer_next  = `TIMER_W'(WRITE_CYCLES);
                    cstate_next = CS_WAIT;
                end
            end
            CS_WAIT:
            begin
                if (timer_reg == '0)
                begin
                    busy_next   = '0;
                    cstate_next = CS_IDLE;
                end
                else
                    timer_next = timer_reg - `TIMER_W'(1);
            end
        endcase
        peek_word = ecc_fix(mem[i_peek_addr[12:2]]);
        peek_next = peek_word[{i_peek_addr[1:0], 3'h0} +: 8];
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            cstate_reg  <= CS_IDLE;
            grp_reg     <= 3'h0;
            timer_reg   <= '0;
            busy_reg    <= '0;
            page_reg    <= 8'h00;
            used_reg    <= '0;
            o_peek_data <= 8'h00;
            sda_o_reg   <= '0;
        end
        else
        begin
            cstate_reg  <= cstate_next;
            grp_reg     <= grp_next;
            timer_reg   <= timer_next;
            busy_reg    <= busy_next;
            page_reg    <= page_next;
            used_reg    <= used_next;
            o_peek_data <= peek_next;
            sda_o_reg   <= '0;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (mem_we)
            mem[{page_reg, grp_reg}] <= mem_wdata;
    end

    assign o_busy  = busy_reg;
    assign o_sda_o = sda_o_reg;

    commit_go_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        (cstate_reg == CS_IDLE && stop_seen && armed_s_reg[1] && !used_reg)
        |=> busy_reg && cstate_reg == CS_MERGE && page_reg == $past(addr_reg[12:5]))
        else $error("armed stop did not start the write");

    commit_skip_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        (cstate_reg == CS_IDLE && !(stop_seen && armed_s_reg[1])) |=> !busy_reg)
        else $error("write started without a tenth-slot stop");

    busy_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        (cstate_reg == CS_WAIT && timer_reg != '0)
        |=> busy_reg && timer_reg == $past(timer_reg) - `TIMER_W'(1))
        else $error("busy dropped before the write timer ran out");

    merge_span_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        $rose(busy_reg) |-> (cstate_reg == CS_MERGE) [*8] ##1 cstate_reg == CS_WAIT)
        else $error("group rewrite did not walk all eight groups");

endmodule

// ### testbench/i2c_ctrl_model.sv
// two-wire bus controller model: start, stop, bytes and reset-time clocks
`timescale 1ns/100ps
module i2c_ctrl_model
#(
    parameter int HALF_NS = 40
)
(
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda
);
    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    // free clocks while the target sits in reset and while its release syncs in; idle clock stays high
    task automatic idle_clocks(input int n);
        repeat (n)
        begin
            #HALF_NS o_scl = 1'b0;
            #HALF_NS o_scl = 1'b1;
        end
    endtask

    // long high time so the slow side catches the data edge
    task automatic start_cond();
        #(HALF_NS/2) o_sda = 1'b1;
        #(HALF_NS/2) o_scl = 1'b1;
        #(3*HALF_NS) o_sda = 1'b0;
        #(3*HALF_NS) o_scl = 1'b0;
    endtask

    // data low before the tenth rise, then release while clock is high
    task automatic stop_cond();
        #(HALF_NS/2) o_sda = 1'b0;
        #(HALF_NS/2) o_scl = 1'b1;
        #(3*HALF_NS) o_sda = 1'b1;
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            #(HALF_NS/2) o_sda = b[i];
            #(HALF_NS/2) o_scl = 1'b1;
            #HALF_NS o_scl = 1'b0;
        end
        #(HALF_NS/2) o_sda = 1'b1;
        #(HALF_NS/2) o_scl = 1'b1;
        #(HALF_NS/2) ack = (i_sda === 1'b0);
        #(HALF_NS/2) o_scl = 1'b0;
    endtask
endmodule

// ### testbench/tb.sv
// self-checking bench for the serial eeprom target write path
`timescale 1ns/100ps
`include "eeprom_i2c_defs.svh"
module tb
    import eeprom_i2c_pkg::*;
;
    // long write time so a second frame lands inside the busy window
    localparam int WCYC = 200;

    logic        clk_sys;
    logic        srst;
    logic        scl;
    logic        drv_sda;
    wire         sda_wire;
    logic        sda_o;
    logic        sda_oe;
    logic [2:0]  chip;
    logic        wp;
    logic [12:0] peek_addr;
    logic [7:0]  peek_data;
    logic        busy;
    logic [7:0]  hi;
    logic [7:0]  lo;
    logic [7:0]  mem [int];
    int          mismatches;
    int          check_count;
    int          cycles;
    int unsigned seed;

    // pull-up wins unless someone pulls low
    assign sda_wire = drv_sda & ~(sda_oe & ~sda_o);

    eeprom_i2c_target #(.WRITE_CYCLES(WCYC)) eeprom_i2c_target_inst (
        .i_clk_sys          (clk_sys),
        .i_srst             (srst),
        .i_scl              (scl),
        .i_sda_i            (sda_wire),
        .o_sda_o            (sda_o),
        .o_sda_oe           (sda_oe),
        .i_chip_sel_bit2    (chip[2]),
        .i_chip_sel_bit1    (chip[1]),
        .i_chip_sel_bit0    (chip[0]),
        .i_write_protect_in (wp),
        .i_peek_addr        (peek_addr),
        .o_peek_data        (peek_data),
        .o_busy             (busy)
    );

    i2c_ctrl_model i2c_ctrl_model_inst (
        .i_sda (sda_wire),
        .o_scl (scl),
        .o_sda (drv_sda)
    );

    always #12.5 clk_sys = ~clk_sys;

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            mismatches++;
            $display("unexpected timeout: expected finish seen hang");
            summarize();
        end
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    // ack expected after byte k of a frame
    function automatic logic exp_ack(input int k, input logic ok, input logic rd,
                                     input logic [3:0] typ, input logic prot);
        if (k == 0)
            return ok;
        if (rd || k < 3)
            return ok && !rd;
        return ok && typ == `TYPE_ARRAY && !prot;
    endfunction

    // nacked data leaves nothing to commit, so no write cycle follows
    function automatic int exp_mode(input logic ok, input logic rd, input int n,
                                    input logic [3:0] typ, input logic prot);
        return (!ok || rd || n == 0 || typ != `TYPE_ARRAY || prot) ? 0 : 1;
    endfunction

    // mode 0: no write expected, 1: write of known length, 2: either
    task automatic wait_write(input int mode, input int exp_len);
        int n;
        n = 0;
        while (busy !== 1'b1 && n < 20)
        begin
            @(posedge clk_sys);
            #2 n++;
        end
        if (mode < 2) check("busy_start", 16'(busy), 16'(mode));
        n = 0;
        while (busy === 1'b1 && n < 600)
        begin
            n++;
            @(posedge clk_sys);
            #2;
        end
        check("busy_end", 16'(busy), 16'h0000);
        if (mode == 1) check("busy_cycles", 16'(n), 16'(exp_len));
    endtask

    task automatic run_frame(input logic [3:0] typ, input logic [2:0] cs, input logic rd,
                             input logic [7:0] a_hi, input logic [7:0] a_lo, input int n,
                             input bit bsy, input bit do_wait);
        sel_byte_t   sel;
        logic [7:0]  b;
        logic        a;
        logic        ok;
        logic        e;
        logic [12:0] ad;
        int          mode;
        sel = '{dev_type: typ, chip: cs, read: rd};
        ok = (typ == `TYPE_ARRAY || typ == `TYPE_IDPAGE) && cs == chip && !bsy;
        ad = {a_hi[4:0], a_lo};
        i2c_ctrl_model_inst.start_cond();
        for (int k = 0; k < n + 3; k++)
        begin
            if (k == 0)
                b = 8'(sel);
            else if (k == 1)
                b = a_hi;
            else if (k == 2)
                b = a_lo;
            else
                b = 8'($urandom);
            e = exp_ack(k, ok, rd, typ, wp);
            i2c_ctrl_model_inst.send_byte(b, a);
            check("ack", 16'(a), 16'(e));
            if (k > 2 && e)
                mem[{ad[12:5], 5'(ad[4:0] + k - 3)}] = b;
        end
        i2c_ctrl_model_inst.stop_cond();
        mode = exp_mode(ok, rd, n, typ, wp);
        if (do_wait)
            wait_write(mode, 8 + WCYC + 1);
    endtask

    task automatic verify_mem();
        foreach (mem[a])
        begin
            @(posedge clk_sys);
            #2 peek_addr = 13'(a);
            @(posedge clk_sys);
            #2 check("peek_data", 16'(peek_data), 16'(mem[a]));
        end
    endtask

    initial
    begin
        clk_sys = 1'b0;
        srst = 1'b1;
        wp = 1'b0;
        peek_addr = 13'h0000;
        mismatches = 0;
        check_count = 0;
        cycles = 0;
        seed = $urandom(61);
        chip = 3'($urandom);
        // link reset needs scl edges while reset is held
        i2c_ctrl_model_inst.idle_clocks(4);
        @(posedge clk_sys);
        #2 srst = 1'b0;
        i2c_ctrl_model_inst.idle_clocks(3);
        hi = 8'($urandom);
        lo = 8'($urandom);
        run_frame(`TYPE_ARRAY, chip, 1'b0, hi, lo, 1, 1'b0, 1'b1);
        $display("test byte write done");
        lo = {3'($urandom), 5'h1E};
        run_frame(`TYPE_ARRAY, chip, 1'b0, hi, lo, 34, 1'b0, 1'b1);
        run_frame(`TYPE_ARRAY, chip, 1'b0, hi, {lo[7:5], 5'h05}, 1, 1'b0, 1'b1);
        $display("test page write done");
        run_frame(`TYPE_ARRAY, chip, 1'b0, hi, lo, 0, 1'b0, 1'b1);
        $display("test stop placement done");
        @(posedge clk_sys);
        #2 wp = 1'b1;
        run_frame(`TYPE_ARRAY, chip, 1'b0, hi, lo, 3, 1'b0, 1'b1);
        @(posedge clk_sys);
        #2 wp = 1'b0;
        $display("test write protect done");
        run_frame(`TYPE_IDPAGE, chip, 1'b0, 8'h00, 8'h03, 2, 1'b0, 1'b1);
        run_frame(`TYPE_ARRAY, chip, 1'b1, 8'hFF, 8'hFF, 0, 1'b0, 1'b1);
        $display("test id page and read select done");
        for (int cs = 0; cs < 8; cs++)
            run_frame(`TYPE_ARRAY, 3'(cs), 1'b0, 8'($urandom), 8'($urandom), 1, 1'b0,
                      1'b1);
        run_frame(4'h5, chip, 1'b0, hi, lo, 1, 1'b0, 1'b1);
        $display("test select decode done");
        run_frame(`TYPE_ARRAY, chip, 1'b0, hi, lo, 2, 1'b0, 1'b0);
        run_frame(`TYPE_ARRAY, chip, 1'b0, hi, lo, 0, 1'b1, 1'b0);
        wait_write(2, 0);
        $display("test busy silence done");
        verify_mem();
        $display("test memory contents done");
        summarize();
    end
endmodule
